/* design/dsc_pkg.sv */
// Package of constants and carrier types for the deserializer strap and control pin block
package dsc_pkg;

  // ************************************************************
  // Widths and strap encodings
  // ************************************************************
  localparam int DSC_BUS_W = 32;
  localparam int DSC_NARROW_W = 24;
  localparam int DSC_EQ_W = 4;
  localparam logic [3:0] DSC_EQ_LOW_BOOST = 4'h9;
  localparam logic [3:0] DSC_EQ_HIGH_BOOST = 4'h4;
  localparam int DSC_AUDIO_W = 3;

  // ************************************************************
  // Control-pin roles
  // ************************************************************
  typedef enum logic [1:0] {
    DSC_ROLE_UART_MASTER = 2'b00,
    DSC_ROLE_UART_SLAVE = 2'b01,
    DSC_ROLE_I2C_SLAVE = 2'b10
  } dsc_role_t;

  // Latched strap set
  typedef struct packed {
    logic bus_width_strap;
    logic launch_edge_strap;
    logic control_direction_strap;
    logic control_mode_strap;
    logic equalizer_preset_strap;
  } dsc_straps_t;

  // Parallel and audio data carried to the output stage
  typedef struct packed {
    logic [DSC_BUS_W-1:0] data;
    logic [DSC_AUDIO_W-1:0] audio;
  } dsc_pix_t;

endpackage : dsc_pkg

/* design/dsc_sync.sv */
// Two-flop synchroniser for a single level
`timescale 1ns/10ps
module dsc_sync import dsc_pkg::*; #(
  parameter logic RESET_VAL = 1'b0
) (
  // Clock and reset
  input wire logic clk,
  input wire logic reset_n,
  // Level in and out
  input wire logic async_in,
  output logic sync_out
);

  logic meta_q;

  // First stage feeds only the second stage
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      meta_q <= RESET_VAL;
      sync_out <= RESET_VAL;
    end else begin
      meta_q <= async_in;
      sync_out <= meta_q;
    end
  end

endmodule : dsc_sync

/* design/dsc_pins.sv */
// Strap latching, output gating, interrupt forwarding and control-pin muxing
`timescale 1ns/10ps
module dsc_pins import dsc_pkg::*; #(
  parameter int BUS_W = DSC_BUS_W,
  parameter int NARROW_W = DSC_NARROW_W
) (
  // Clock and power-down reset
  input wire logic clk,
  input wire logic reset_n,
  // Strap inputs
  input wire logic bus_width_strap,
  input wire logic launch_edge_strap,
  input wire logic control_direction_strap,
  input wire logic control_mode_strap,
  input wire logic equalizer_preset_strap,
  // Latched configuration
  output logic [DSC_EQ_W-1:0] equalizer_tuning_field,
  output logic wide_bus,
  output logic falling_launch,
  output dsc_role_t control_role,
  output logic link_mode_sel,
  output logic autostart_sel,
  // Parallel output stage
  input wire logic output_enable_n,
  input wire dsc_pix_t pix_in,
  output dsc_pix_t pix_out,
  output logic pix_oe,
  output logic pixel_clock_out,
  output logic pixel_clock_oe,
  // Interrupt forwarding
  input wire logic int_in,
  output logic int_toggle_event,
  // General-purpose open-drain pins
  input wire logic [1:0] gp_drive_low,
  input wire logic general_pin_a_in,
  input wire logic general_pin_b_in,
  output logic general_pin_a_out,
  output logic general_pin_a_oe,
  output logic general_pin_b_out,
  output logic general_pin_b_oe,
  output logic [1:0] gp_level,
  // Control engine side
  input wire logic uart_tx,
  output logic uart_rx,
  input wire logic i2c_scl_low,
  input wire logic i2c_sda_low,
  output logic i2c_sda_in,
  input wire logic use_i2c,
  // Shared control pins
  input wire logic rx_data_pin_in,
  output logic rx_data_pin_out,
  output logic rx_data_pin_oe,
  output logic tx_clock_pin_out,
  output logic tx_clock_pin_oe
);

  // ************************************************************
  // Strap capture
  // ************************************************************
  // Capture in a clocked process after reset release, never from reset itself
  dsc_straps_t straps_q;
  logic latch_pend_q;

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      latch_pend_q <= 1'b1;
      straps_q <= '0;
    end else if (latch_pend_q) begin
      latch_pend_q <= 1'b0;
      straps_q <= '{bus_width_strap, launch_edge_strap, control_direction_strap,
                    control_mode_strap, equalizer_preset_strap};
    end
  end

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      equalizer_tuning_field <= DSC_EQ_LOW_BOOST;
    end else if (latch_pend_q) begin
      equalizer_tuning_field <= equalizer_preset_strap ? DSC_EQ_HIGH_BOOST : DSC_EQ_LOW_BOOST;
    end
  end

  assign wide_bus = straps_q.bus_width_strap;
  assign falling_launch = straps_q.launch_edge_strap;

  always_comb begin
    if (straps_q.control_direction_strap) begin
      control_role = DSC_ROLE_UART_MASTER;
    end else if (use_i2c) begin
      control_role = DSC_ROLE_I2C_SLAVE;
    end else begin
      control_role = DSC_ROLE_UART_SLAVE;
    end
  end

  assign link_mode_sel = straps_q.control_direction_strap & straps_q.control_mode_strap;
  assign autostart_sel = ~straps_q.control_direction_strap & straps_q.control_mode_strap;

  // ************************************************************
  // Parallel output stage
  // ************************************************************
  logic [BUS_W-1:0] width_mask;
  logic clk_div_q;
  logic launch_tick;
  logic [BUS_W-1:0] data_q;
  logic [DSC_AUDIO_W-1:0] audio_q;

  // Upper lanes stay low in narrow mode
  assign width_mask = wide_bus ? {BUS_W{1'b1}} : {{(BUS_W-NARROW_W){1'b0}}, {NARROW_W{1'b1}}};

  // Pixel clock is the system clock halved so both edges are visible
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      clk_div_q <= 1'b0;
    end else begin
      clk_div_q <= ~clk_div_q;
    end
  end

  assign launch_tick = falling_launch ? clk_div_q : ~clk_div_q;

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      data_q <= '0;
      audio_q <= '0;
    end else if (launch_tick) begin
      data_q <= pix_in.data & width_mask;
      audio_q <= pix_in.audio;
    end
  end

  assign pix_out = '{data_q, audio_q};
  assign pix_oe = ~output_enable_n;
  assign pixel_clock_out = clk_div_q;
  assign pixel_clock_oe = ~output_enable_n;

  // ************************************************************
  // Interrupt forwarding
  // ************************************************************
  // Cycles until the synchroniser and the previous-level flop both hold real pin samples
  localparam int INT_SETTLE = 3;
  logic int_sync;
  logic int_prev_q;
  logic [INT_SETTLE-1:0] int_arm_q;

  dsc_sync #(.RESET_VAL(1'b0)) u_int_sync (
    .clk(clk),
    .reset_n(reset_n),
    .async_in(int_in),
    .sync_out(int_sync)
  );

  // Compares wait until the flops hold pin samples, so a pin idling high is no false edge
  // Limitation: a pin change during power-down, before the first sample after exit, is not forwarded
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      int_prev_q <= 1'b0;
      int_arm_q <= '0;
    end else begin
      int_prev_q <= int_sync;
      int_arm_q <= {int_arm_q[INT_SETTLE-2:0], 1'b1};
    end
  end

  assign int_toggle_event = int_arm_q[INT_SETTLE-1] & (int_sync ^ int_prev_q);

  // ************************************************************
  // General-purpose pins
  // ************************************************************
  // open-drain, released in reset
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      general_pin_a_oe <= 1'b0;
      general_pin_b_oe <= 1'b0;
    end else begin
      general_pin_a_oe <= gp_drive_low[0];
      general_pin_b_oe <= gp_drive_low[1];
    end
  end

  assign general_pin_a_out = 1'b0;
  assign general_pin_b_out = 1'b0;
  assign gp_level = {general_pin_b_in, general_pin_a_in};

  // ************************************************************
  // Shared control pins
  // ************************************************************
  logic i2c_mode;
  assign i2c_mode = (control_role == DSC_ROLE_I2C_SLAVE);

  assign uart_rx = i2c_mode ? 1'b1 : rx_data_pin_in;
  assign i2c_sda_in = i2c_mode ? rx_data_pin_in : 1'b1;

  assign rx_data_pin_out = 1'b0;
  assign rx_data_pin_oe = reset_n & i2c_mode & i2c_sda_low;

  // clock pin role, open-drain per pin type
  assign tx_clock_pin_out = 1'b0;
  assign tx_clock_pin_oe = reset_n & (i2c_mode ? i2c_scl_low : ~uart_tx);

endmodule : dsc_pins

/* bench/dsc_far_model.sv */
// Far-side pull-ups plus a peripheral that can pull lines low
`timescale 1ns/10ps
module dsc_far_model (
  input logic general_pin_a_oe, general_pin_b_oe, rx_data_pin_oe, tx_clock_pin_oe,
  input logic [2:0] ext_low,
  output logic general_pin_a_in, general_pin_b_in, rx_data_pin_in, scl
);
  assign general_pin_a_in = ~(general_pin_a_oe | ext_low[0]);
  assign general_pin_b_in = ~(general_pin_b_oe | ext_low[1]);
  assign rx_data_pin_in = ~(rx_data_pin_oe | ext_low[2]);
  assign scl = ~tx_clock_pin_oe;
endmodule : dsc_far_model

/* bench/dsc_pins_sva.sv */
// Port checker for the strap and control pin block
`timescale 1ns/10ps
module dsc_pins_sva import dsc_pkg::*; (
  input logic clk, reset_n, output_enable_n, pix_oe, pixel_clock_oe, wide_bus, equalizer_preset_strap,
  input logic int_in, int_toggle_event, link_mode_sel, uart_tx, i2c_scl_low, i2c_sda_low,
  input logic general_pin_a_oe, general_pin_b_oe, rx_data_pin_oe, tx_clock_pin_oe,
  input logic [DSC_EQ_W-1:0] equalizer_tuning_field,
  input dsc_pix_t pix_out,
  input dsc_role_t control_role
);
  default clocking @(posedge clk); endclocking
  default disable iff (!reset_n);
  oe_gate_a: assert property (pix_oe == !output_enable_n && pixel_clock_oe == pix_oe) else $error("oe");
  narrow_zero_a: assert property (!wide_bus |-> pix_out.data[31:24] == 8'h00) else $error("narrow");
  eq_preset_a: assert property ($rose(reset_n) |=> equalizer_tuning_field ==
    ($past(equalizer_preset_strap) ? DSC_EQ_HIGH_BOOST : DSC_EQ_LOW_BOOST)) else $error("eq preset");
  eq_hold_a: assert property ($past(reset_n, 2) |-> $stable(equalizer_tuning_field) && $stable(wide_bus))
    else $error("strap hold");
  int_fwd_a: assert property ($changed(int_in) |-> ##2 int_toggle_event) else $error("int fwd");
  gp_release_a: assert property (disable iff (1'b0) !reset_n |-> !general_pin_a_oe && !general_pin_b_oe)
    else $error("gp release");
  role_dir_a: assert property (link_mode_sel |-> control_role == DSC_ROLE_UART_MASTER) else $error("role");
  i2c_pins_a: assert property (control_role == DSC_ROLE_I2C_SLAVE |->
    tx_clock_pin_oe == i2c_scl_low && rx_data_pin_oe == i2c_sda_low) else $error("i2c pins");
  uart_tx_a: assert property (control_role != DSC_ROLE_I2C_SLAVE |-> tx_clock_pin_oe == !uart_tx)
    else $error("uart tx");
endmodule : dsc_pins_sva
bind dsc_pins dsc_pins_sva dsc_pins_sva_inst (
  .clk(clk), .reset_n(reset_n), .output_enable_n(output_enable_n), .pix_oe(pix_oe),
  .pixel_clock_oe(pixel_clock_oe), .wide_bus(wide_bus), .equalizer_preset_strap(equalizer_preset_strap),
  .int_in(int_in), .int_toggle_event(int_toggle_event), .link_mode_sel(link_mode_sel), .uart_tx(uart_tx),
  .i2c_scl_low(i2c_scl_low), .i2c_sda_low(i2c_sda_low), .general_pin_a_oe(general_pin_a_oe),
  .general_pin_b_oe(general_pin_b_oe), .rx_data_pin_oe(rx_data_pin_oe), .tx_clock_pin_oe(tx_clock_pin_oe),
  .equalizer_tuning_field(equalizer_tuning_field), .pix_out(pix_out), .control_role(control_role)
);

/* bench/dsc_pins_bench.sv */
// Self-checking bench for the strap and control pin block
`timescale 1ns/10ps
module dsc_pins_bench import dsc_pkg::*;;
  logic clk, reset_n, bus_width_strap, launch_edge_strap, control_direction_strap, control_mode_strap;
  logic equalizer_preset_strap, output_enable_n, int_in, uart_tx, i2c_scl_low, i2c_sda_low, use_i2c, uart_rx;
  logic general_pin_a_in, general_pin_b_in, rx_data_pin_in, scl, wide_bus, falling_launch, link_mode_sel;
  logic autostart_sel, pix_oe, pixel_clock_out, pixel_clock_oe, int_toggle_event, general_pin_a_out;
  logic general_pin_a_oe, general_pin_b_out, general_pin_b_oe, i2c_sda_in, rx_data_pin_out, rx_data_pin_oe;
  logic tx_clock_pin_out, tx_clock_pin_oe;
  logic [1:0] gp_drive_low, gp_level;
  logic [2:0] ext_low;
  logic [DSC_EQ_W-1:0] equalizer_tuning_field;
  dsc_pix_t pix_in, pix_out;
  dsc_role_t control_role;
  int failures = 0, checks_done = 0;
  logic [31:0] n;
  dsc_pins dsc_pins_inst (
    .clk(clk), .reset_n(reset_n), .bus_width_strap(bus_width_strap), .launch_edge_strap(launch_edge_strap),
    .control_direction_strap(control_direction_strap), .control_mode_strap(control_mode_strap),
    .equalizer_preset_strap(equalizer_preset_strap), .equalizer_tuning_field(equalizer_tuning_field),
    .wide_bus(wide_bus), .falling_launch(falling_launch), .control_role(control_role),
    .link_mode_sel(link_mode_sel), .autostart_sel(autostart_sel), .output_enable_n(output_enable_n),
    .pix_in(pix_in), .pix_out(pix_out), .pix_oe(pix_oe), .pixel_clock_out(pixel_clock_out),
    .pixel_clock_oe(pixel_clock_oe), .int_in(int_in), .int_toggle_event(int_toggle_event),
    .gp_drive_low(gp_drive_low), .general_pin_a_in(general_pin_a_in), .general_pin_b_in(general_pin_b_in),
    .general_pin_a_out(general_pin_a_out), .general_pin_a_oe(general_pin_a_oe),
    .general_pin_b_out(general_pin_b_out), .general_pin_b_oe(general_pin_b_oe), .gp_level(gp_level),
    .uart_tx(uart_tx), .uart_rx(uart_rx), .i2c_scl_low(i2c_scl_low), .i2c_sda_low(i2c_sda_low),
    .i2c_sda_in(i2c_sda_in), .use_i2c(use_i2c), .rx_data_pin_in(rx_data_pin_in),
    .rx_data_pin_out(rx_data_pin_out), .rx_data_pin_oe(rx_data_pin_oe), .tx_clock_pin_out(tx_clock_pin_out),
    .tx_clock_pin_oe(tx_clock_pin_oe)
  );
  dsc_far_model dsc_far_model_inst (
    .general_pin_a_oe(general_pin_a_oe), .general_pin_b_oe(general_pin_b_oe), .rx_data_pin_oe(rx_data_pin_oe),
    .tx_clock_pin_oe(tx_clock_pin_oe), .ext_low(ext_low), .general_pin_a_in(general_pin_a_in),
    .general_pin_b_in(general_pin_b_in), .rx_data_pin_in(rx_data_pin_in), .scl(scl)
  );
  initial begin
    clk = 1'b0;
    forever #25 clk = ~clk;
  end
  task chk(input logic [31:0] seen, input logic [31:0] exp);
    checks_done++;
    if (seen !== exp) begin
      failures++;
      $display("CHECK FAILED at %0t: saw %h expected %h", $time, seen, exp);
    end
  endtask : chk
  task summarize;
    $display("checks %0d failures %0d", checks_done, failures);
    if (failures == 0 && checks_done > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask : summarize
  // Straps flip after the latch edge to prove they are ignored
  task strap_reset(input logic [4:0] s);
    @(posedge clk) reset_n <= 1'b0;
    {bus_width_strap, launch_edge_strap, control_direction_strap, control_mode_strap, equalizer_preset_strap} <= s;
    repeat (5) @(posedge clk);
    @(negedge clk) chk({general_pin_a_oe, general_pin_b_oe, tx_clock_pin_oe, equalizer_tuning_field}, 7'h09);
    @(posedge clk) reset_n <= 1'b1;
    // A still interrupt pin must give no toggle after power-down exit
    n = 0;
    repeat (6) @(negedge clk) n += int_toggle_event;
    chk(n, 0);
    @(posedge clk) {bus_width_strap, launch_edge_strap, control_direction_strap, control_mode_strap,
                    equalizer_preset_strap} <= ~s;
    repeat (3) @(negedge clk);
  endtask : strap_reset
  initial begin
    #100000;
    failures++;
    summarize;
  end
  initial begin
    {reset_n, int_in, i2c_scl_low, i2c_sda_low, use_i2c, ext_low} = '0;
    {output_enable_n, uart_tx, gp_drive_low} = '1;
    pix_in = '1;
    strap_reset(5'b11011);
    chk({wide_bus, falling_launch, link_mode_sel, autostart_sel, equalizer_tuning_field}, 8'hD4);
    @(posedge clk) gp_drive_low <= 2'b01;
    use_i2c <= 1'b1;
    i2c_scl_low <= 1'b1;
    @(posedge clk);
    @(negedge clk) chk({gp_level, control_role, scl, i2c_sda_in}, 6'h29);
    @(posedge clk) ext_low <= 3'b110;
    @(negedge clk) chk({gp_level, i2c_sda_in}, 3'h0);
    @(posedge clk) {use_i2c, uart_tx, ext_low, output_enable_n} <= '0;
    i2c_sda_low <= 1'b1;
    @(negedge clk) chk({control_role, scl, uart_rx, rx_data_pin_oe, pix_oe, pixel_clock_oe}, 7'h2B);
    chk(pix_out.data, 32'hFFFFFFFF);
    // Interrupt pin idles high across the next power-down
    @(posedge clk) int_in <= 1'b1;
    strap_reset(5'b00110);
    chk({wide_bus, falling_launch, link_mode_sel, control_role, equalizer_tuning_field}, 9'h049);
    chk(pix_out.data, 32'h00FFFFFF);
    @(posedge clk) output_enable_n <= 1'b1;
    @(negedge clk) chk({pix_oe, pixel_clock_oe}, 2'b00);
    repeat (2) begin
      @(posedge clk) int_in <= ~int_in;
      n = 0;
      repeat (8) @(negedge clk) n += int_toggle_event;
      chk(n, 1);
    end
    summarize;
  end
endmodule : dsc_pins_bench
